/* imcl_cfg.svh */
// constants for the interference monitor and settings lock block
// assumes a 100 MHz clock and an Avalon-MM register slave
`ifndef IMCL_CFG_SVH
`define IMCL_CFG_SVH
`define IMCL_ADDR_CTRL 4'h0
`define IMCL_ADDR_THR 4'h1
`define IMCL_ADDR_LOCK 4'h2
`define IMCL_ADDR_STATUS 4'h3
`define IMCL_ADDR_NOISE 4'h4
`define IMCL_ADDR_BOOT 4'h5
`define IMCL_CTRL_EN_BIT 0
`define IMCL_CTRL_ACT_BIT 1
`define IMCL_LOCK_RAM_BIT 0
`define IMCL_LOCK_BATTERY_BIT 1
`define IMCL_LOCK_FLASH_BIT 2
`define IMCL_THR_BB_RST 8'h0A
`define IMCL_THR_NB_RST 8'h0A
`define IMCL_UNMAPPED_DATA 32'hDEAD_BEEF
`endif

/* imcl_pkg.sv */
// types for the interference monitor and settings lock block
// assumes imcl_cfg.svh holds the numeric constants
package imcl_pkg;
    typedef enum logic [1:0] {
        IMCL_UNKNOWN = 2'h0,
        IMCL_OK = 2'h1,
        IMCL_WARNING = 2'h2,
        IMCL_CRITICAL = 2'h3
    } imcl_bb_state_type;
    typedef enum logic [1:0] {IMCL_BOOT_CHECK, IMCL_BOOT_RUN, IMCL_BOOT_HALT} imcl_boot_type;
endpackage

/* imcl_monitor.sv */
// interference monitor, settings lock, boot and update gating
// assumes measurement inputs arrive on clk from the rf front end logic
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "imcl_cfg.svh"
module imcl_monitor import imcl_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // measurements
    input wire logic [7:0] noise_db,
    input wire logic [7:0] cw_db,
    input wire logic fix_valid,
    input wire logic antenna_ok,
    input wire logic antenna_active,
    input wire logic spoof_suspect,
    // memory layers
    input wire logic battery_cleared,
    input wire logic flash_erase,
    input wire logic flash_lock_in,
    // firmware signature checks
    input wire logic boot_sig_done,
    input wire logic boot_sig_ok,
    input wire logic upd_sig_done,
    input wire logic upd_sig_ok,
    // status outputs
    output logic [1:0] bb_state,
    output logic [7:0] narrowband_jam_level,
    output logic cw_alarm,
    output logic spoof_detect,
    output logic fw_run,
    output logic upd_accept,
    output logic upd_reject,
    output logic flash_lock_out
);
    typedef struct packed {
        logic [31:0] rdata;
        logic wait_n;
        logic en;
        logic ant_active;
        logic [7:0] thr_bb;
        logic [7:0] thr_nb;
        logic lock_ram;
        logic lock_battery;
        logic lock_flash;
        logic lock_merged;
        logic merged_done;
        logic ref_valid;
        logic [7:0] ref_noise;
        logic [1:0] state;
        logic [7:0] jam;
        logic cw;
        logic spoof_prev;
        logic genuine_seen;
        logic spoof;
        logic [7:0] rej_cnt;
        logic [1:0] boot;
        logic upd_acc;
        logic upd_rej;
        logic waitreq;
        logic run;
    } imcl_st_type;

    imcl_st_type st_ff;
    imcl_st_type nxt_st;
    logic [8:0] excess;

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    function automatic logic is_cfg(input logic [3:0] a);
        is_cfg = (a == `IMCL_ADDR_CTRL) || (a == `IMCL_ADDR_THR) || (a == `IMCL_ADDR_LOCK);
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.upd_acc = 1'b0;
        nxt_st.upd_rej = 1'b0;
        // flash layer loaded once after reset
        if (!st_ff.merged_done) begin
            nxt_st.lock_flash = flash_lock_in;
            nxt_st.merged_done = 1'b1;
        end
        // battery and flash layers cleared with their memory
        if (battery_cleared) begin
            nxt_st.lock_battery = 1'b0;
        end
        if (flash_erase) begin
            nxt_st.lock_flash = 1'b0;
        end
        // bus access, one wait cycle then answer
        nxt_st.wait_n = 1'b0;
        if ((avs_read || avs_write) && !st_ff.wait_n) begin
            nxt_st.wait_n = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            if (avs_write && is_cfg(avs_address)) begin
                if (st_ff.lock_merged) begin
                    nxt_st.rej_cnt = st_ff.rej_cnt + 8'h01;
                end else if (avs_byteenable[0]) begin
                    case (avs_address)
                        `IMCL_ADDR_CTRL: begin
                            nxt_st.en = avs_writedata[`IMCL_CTRL_EN_BIT];
                            nxt_st.ant_active = avs_writedata[`IMCL_CTRL_ACT_BIT];
                        end
                        `IMCL_ADDR_THR: begin
                            nxt_st.thr_bb = avs_writedata[7:0];
                            if (avs_byteenable[1]) begin
                                nxt_st.thr_nb = avs_writedata[15:8];
                            end
                        end
                        `IMCL_ADDR_LOCK: begin
                            nxt_st.lock_ram = nxt_st.lock_ram | avs_writedata[`IMCL_LOCK_RAM_BIT];
                            if (avs_writedata[`IMCL_LOCK_BATTERY_BIT]) begin
                                nxt_st.lock_battery = 1'b1;
                            end
                            if (avs_writedata[`IMCL_LOCK_FLASH_BIT]) begin
                                nxt_st.lock_flash = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end else if (avs_read) begin
                // reads never change state, locked or not
                case (avs_address)
                    `IMCL_ADDR_CTRL: nxt_st.rdata = {30'h0, st_ff.ant_active, st_ff.en};
                    `IMCL_ADDR_THR: nxt_st.rdata = {16'h0, st_ff.thr_nb, st_ff.thr_bb};
                    `IMCL_ADDR_LOCK: nxt_st.rdata = {24'h0, st_ff.rej_cnt[3:0],
                        st_ff.lock_merged, st_ff.lock_flash, st_ff.lock_battery, st_ff.lock_ram};
                    `IMCL_ADDR_STATUS: nxt_st.rdata = {28'h0, st_ff.spoof, st_ff.cw,
                        st_ff.state};
                    `IMCL_ADDR_NOISE: nxt_st.rdata = {16'h0, st_ff.ref_noise, st_ff.jam};
                    `IMCL_ADDR_BOOT: nxt_st.rdata = {30'h0, st_ff.boot};
                    default: nxt_st.rdata = `IMCL_UNMAPPED_DATA;
                endcase
            end
        end
        // run-time lock merges all layers
        nxt_st.lock_merged = nxt_st.lock_ram | nxt_st.lock_battery
            | nxt_st.lock_flash;
        // narrow-band level, always running
        nxt_st.jam = cw_db;
        nxt_st.cw = (cw_db > st_ff.thr_nb);
        // broadband monitor, independent of narrow-band path
        if (!st_ff.en || !antenna_ok) begin
            nxt_st.state = IMCL_UNKNOWN;
        end else if (!st_ff.ref_valid) begin
            nxt_st.state = IMCL_UNKNOWN;
            if (fix_valid) begin
                nxt_st.ref_valid = 1'b1;
                nxt_st.ref_noise = noise_db;
            end
        end else if (excess > {1'b0, st_ff.thr_bb}) begin
            nxt_st.state = fix_valid ? IMCL_WARNING : IMCL_CRITICAL;
        end else begin
            nxt_st.state = IMCL_OK;
        end
        if (!st_ff.en) begin
            nxt_st.ref_valid = 1'b0;
        end
        // spoofing on a genuine to counterfeit edge only
        nxt_st.spoof_prev = spoof_suspect;
        if (!spoof_suspect) begin
            nxt_st.genuine_seen = 1'b1;
        end
        if (spoof_suspect && !st_ff.spoof_prev && st_ff.genuine_seen) begin
            nxt_st.spoof = 1'b1;
        end else if (!spoof_suspect) begin
            nxt_st.spoof = 1'b0;
        end
        // boot gating
        case (st_ff.boot)
            IMCL_BOOT_CHECK: begin
                if (boot_sig_done) begin
                    nxt_st.boot = boot_sig_ok ? IMCL_BOOT_RUN : IMCL_BOOT_HALT;
                end
            end
            IMCL_BOOT_RUN: begin
            end
            IMCL_BOOT_HALT: begin
            end
            default: nxt_st.boot = IMCL_BOOT_HALT;
        endcase
        // update gating
        if (upd_sig_done) begin
            nxt_st.upd_acc = upd_sig_ok;
            nxt_st.upd_rej = !upd_sig_ok;
        end
        // registered copies for the output pins
        nxt_st.waitreq = !nxt_st.wait_n;
        nxt_st.run = (nxt_st.boot == IMCL_BOOT_RUN);
    end

    // passive antenna sees less gain, so add a 3 dB margin
    always_comb begin
        if (noise_db > st_ff.ref_noise) begin
            excess = {1'b0, noise_db - st_ff.ref_noise};
        end else begin
            excess = 9'h000;
        end
        if (!st_ff.ant_active && excess >= 9'h003) begin
            excess = excess - 9'h003;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.thr_bb <= `IMCL_THR_BB_RST;
            st_ff.thr_nb <= `IMCL_THR_NB_RST;
            st_ff.boot <= IMCL_BOOT_CHECK;
            st_ff.waitreq <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = st_ff.waitreq;
    assign bb_state = st_ff.state;
    assign narrowband_jam_level = st_ff.jam;
    assign cw_alarm = st_ff.cw;
    assign spoof_detect = st_ff.spoof;
    assign fw_run = st_ff.run;
    assign upd_accept = st_ff.upd_acc;
    assign upd_reject = st_ff.upd_rej;
    assign flash_lock_out = st_ff.lock_flash;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_DISABLED_UNKNOWN: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.en |=> bb_state == 2'h0)
        else $error("disabled monitor not unknown");

    AST_ANT_MISSING: assert property (@(posedge clk) disable iff (!reset_n)
        !antenna_ok |=> bb_state == 2'h0)
        else $error("missing antenna not unknown");

    AST_RESET_DISABLED: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> !st_ff.en)
        else $error("monitor enabled at reset");

    AST_EN_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.lock_merged && avs_write && !st_ff.wait_n && avs_byteenable[0]
        && avs_address == `IMCL_ADDR_CTRL |=> st_ff.en == $past(avs_writedata[`IMCL_CTRL_EN_BIT]))
        else $error("enable write lost");

    AST_ANT_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.lock_merged && avs_write && !st_ff.wait_n && avs_byteenable[0]
        && avs_address == `IMCL_ADDR_CTRL
        |=> st_ff.ant_active == $past(avs_writedata[`IMCL_CTRL_ACT_BIT]))
        else $error("antenna type write lost");

    // ----------------------------------------
    // broadband states
    // ----------------------------------------
    AST_NO_REF_UNKNOWN: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.ref_valid |=> bb_state == 2'h0)
        else $error("state before reference");

    AST_REF_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.en && antenna_ok && !st_ff.ref_valid && fix_valid
        |=> st_ff.ref_valid && st_ff.ref_noise == $past(noise_db))
        else $error("reference not captured");

    AST_OK_STATE: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.en && antenna_ok && st_ff.ref_valid && excess <= {1'b0, st_ff.thr_bb}
        |=> bb_state == 2'h1)
        else $error("quiet noise not ok");

    AST_WARN_STATE: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.en && antenna_ok && st_ff.ref_valid && excess > {1'b0, st_ff.thr_bb} && fix_valid
        |=> bb_state == 2'h2)
        else $error("noise with fix not warning");

    AST_CRIT_STATE: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.en && antenna_ok && st_ff.ref_valid && excess > {1'b0, st_ff.thr_bb} && !fix_valid
        |=> bb_state == 2'h3)
        else $error("noise without fix not critical");

    AST_CRIT_NOFIX: assert property (@(posedge clk) disable iff (!reset_n)
        bb_state == 2'h3 |-> !$past(fix_valid))
        else $error("critical with fix");

    AST_WARN_FIX: assert property (@(posedge clk) disable iff (!reset_n)
        bb_state == 2'h2 |-> $past(fix_valid))
        else $error("warning without fix");

    AST_STATUS_READ: assert property (@(posedge clk) disable iff (!reset_n)
        avs_read && !st_ff.wait_n && avs_address == `IMCL_ADDR_STATUS
        |=> avs_readdata[1:0] == $past(bb_state))
        else $error("status field mismatch");

    // ----------------------------------------
    // narrow-band path and spoofing
    // ----------------------------------------
    AST_JAM_FOLLOWS: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> narrowband_jam_level == $past(cw_db))
        else $error("jam level stale");

    AST_CW_ALARM: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> cw_alarm == ($past(cw_db) > $past(st_ff.thr_nb)))
        else $error("cw alarm wrong");

    AST_SPOOF_EDGE: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(spoof_detect) |-> $past(st_ff.genuine_seen))
        else $error("spoof no genuine");

    AST_SPOOF_START: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.genuine_seen |=> !spoof_detect)
        else $error("spoof raised at start");

    // ----------------------------------------
    // settings lock
    // ----------------------------------------
    AST_LOCK_BLOCKS: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.lock_merged && avs_write && !st_ff.wait_n && is_cfg(avs_address)
        |=> $stable(st_ff.en) && $stable(st_ff.thr_bb))
        else $error("locked write taken");

    AST_LOCK_THR_NB: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.lock_merged && avs_write && !st_ff.wait_n && is_cfg(avs_address)
        |=> $stable(st_ff.thr_nb) && $stable(st_ff.ant_active))
        else $error("locked write changed setting");

    AST_LOCK_COUNT: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.lock_merged && avs_write && !st_ff.wait_n && is_cfg(avs_address)
        |=> st_ff.rej_cnt == $past(st_ff.rej_cnt) + 8'h01)
        else $error("refused write not counted");

    AST_MERGE: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |-> st_ff.lock_merged == (st_ff.lock_ram | st_ff.lock_battery | st_ff.lock_flash))
        else $error("merged lock wrong");

    AST_READ_NO_EFFECT: assert property (@(posedge clk) disable iff (!reset_n)
        avs_read && !avs_write && !st_ff.wait_n
        |=> $stable(st_ff.en) && $stable(st_ff.thr_bb) && $stable(st_ff.thr_nb))
        else $error("read changed setting");

    AST_ANSWERED: assert property (@(posedge clk) disable iff (!reset_n)
        (avs_read || avs_write) && !st_ff.wait_n |=> !avs_waitrequest)
        else $error("request not answered");

    AST_RAM_RESET: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> !st_ff.lock_ram && !st_ff.lock_battery)
        else $error("volatile lock survived reset");

    AST_BATTERY_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        battery_cleared && !avs_write |=> !st_ff.lock_battery)
        else $error("battery lock kept");

    AST_FLASH_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.merged_done && !flash_erase && !avs_write
        |=> flash_lock_out == $past(flash_lock_in))
        else $error("flash lock not loaded");

    AST_FLASH_ERASE: assert property (@(posedge clk) disable iff (!reset_n)
        flash_erase && !avs_write |=> !flash_lock_out)
        else $error("flash lock kept");

    // ----------------------------------------
    // boot and update gating
    // ----------------------------------------
    AST_BOOT_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(fw_run) |-> $past(boot_sig_ok))
        else $error("boot without signature");

    AST_BOOT_HALT: assert property (@(posedge clk) disable iff (!reset_n)
        boot_sig_done && !boot_sig_ok && st_ff.boot == IMCL_BOOT_CHECK |=> !fw_run)
        else $error("bad image started");

    AST_UPD_REJ: assert property (@(posedge clk) disable iff (!reset_n)
        upd_sig_done && !upd_sig_ok |=> upd_reject && !upd_accept)
        else $error("bad update");

    AST_UPD_ACC: assert property (@(posedge clk) disable iff (!reset_n)
        upd_sig_done && upd_sig_ok |=> upd_accept && !upd_reject)
        else $error("good update refused");
endmodule

/* imcl_layer_model.sv */
// far-side model: flash layer store and signature checker for the block
// assumes the block loads flash_lock_in at the first edge after reset
`timescale 1ns/1ps
module imcl_layer_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bench controls
    input wire logic boot_good,
    input wire logic upd_req,
    input wire logic upd_good,
    // flash layer
    input wire logic flash_lock_out,
    output logic flash_lock_in,
    // signature results
    output logic boot_sig_done,
    output logic boot_sig_ok,
    output logic upd_sig_done,
    output logic upd_sig_ok
);
    logic flash_mem = 1'b0;
    logic [2:0] cnt_ff;
    // ---------------------------------------------------------------
    // flash survives reset, boot check after start
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 3'h0;
        end else if (cnt_ff != 3'h7) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset_n && cnt_ff == 3'h7) begin
            flash_mem <= flash_lock_out;
        end
        upd_sig_done <= upd_req;
    end
    assign flash_lock_in = flash_mem;
    assign boot_sig_done = reset_n && cnt_ff == 3'h3;
    assign boot_sig_ok = boot_sig_done ? boot_good : ~boot_good;
    assign upd_sig_ok = upd_sig_done ? upd_good : ~upd_good;
endmodule

/* test_interference_monitor_config_lock.sv */
// self-checking bench for imcl_monitor
// assumes imcl_layer_model stands in for flash store and signature unit
`timescale 1ns/1ps
`include "imcl_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module test_interference_monitor_config_lock;
    import imcl_pkg::*;
    logic clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, fix_valid = 0, antenna_ok = 1;
    logic [3:0] avs_address = 0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 0, avs_readdata, s = 32'h6518;
    logic [7:0] noise_db = 0, cw_db = 0, narrowband_jam_level;
    logic avs_waitrequest, spoof_suspect = 1, battery_cleared = 0, flash_erase = 0, flash_lock_out;
    logic antenna_active = 0;
    logic [31:0] got_v, exp_v;
    logic boot_good = 1, upd_req = 0, upd_good = 0, flash_lock_in, cw_alarm, spoof_detect;
    logic boot_sig_done, boot_sig_ok, upd_sig_done, upd_sig_ok, fw_run, upd_accept, upd_reject;
    logic [1:0] bb_state;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0] acc_n = 0, rej_n = 0;
    int num_errors = 0, total_checks = 0;
    logic [31:0] tbl[9] = '{32'h3_28_1_1, 32'h3_32_1_1, 32'h3_33_1_2, 32'h3_33_0_3, 32'h1_35_1_1,
        32'h1_36_1_2, 32'h3_36_2_0, 32'h0_36_1_0, 32'h3_28_1_1};
    imcl_monitor u_imcl_monitor (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .noise_db(noise_db),
        .cw_db(cw_db), .fix_valid(fix_valid), .antenna_ok(antenna_ok),
        .antenna_active(antenna_active), .spoof_suspect(spoof_suspect),
        .battery_cleared(battery_cleared), .flash_erase(flash_erase),
        .flash_lock_in(flash_lock_in), .boot_sig_done(boot_sig_done), .boot_sig_ok(boot_sig_ok),
        .upd_sig_done(upd_sig_done), .upd_sig_ok(upd_sig_ok), .bb_state(bb_state),
        .narrowband_jam_level(narrowband_jam_level), .cw_alarm(cw_alarm),
        .spoof_detect(spoof_detect), .fw_run(fw_run), .upd_accept(upd_accept),
        .upd_reject(upd_reject), .flash_lock_out(flash_lock_out)
    );
    imcl_layer_model u_imcl_layer_model (
        .clk(clk), .reset_n(reset_n), .boot_good(boot_good), .upd_req(upd_req),
        .upd_good(upd_good), .flash_lock_out(flash_lock_out), .flash_lock_in(flash_lock_in),
        .boot_sig_done(boot_sig_done), .boot_sig_ok(boot_sig_ok), .upd_sig_done(upd_sig_done),
        .upd_sig_ok(upd_sig_ok)
    );
    initial forever #5 clk = ~clk;
    initial begin #400000; num_errors++; summarize(); end
    always @(posedge clk) begin
        acc_n <= acc_n + 8'(upd_accept);
        rej_n <= rej_n + 8'(upd_reject);
        if (avs_read && avs_waitrequest === 1'b0) begin
            got_v = avs_readdata & msk_q.pop_front();
            exp_v = exp_q.pop_front();
            `CHK(got_v, exp_v)
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a; avs_write <= wr; avs_read <= !wr; avs_writedata <= d;
        do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        avs_read <= 1'b0; avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e); msk_q.push_back(m); bus(1'b0, a, 32'h0);
    endtask
    task automatic do_reset();
        @(posedge clk); reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        if (k == 0) battery_cleared <= 1'b1;
        else if (k == 1) flash_erase <= 1'b1;
        else upd_req <= 1'b1;
        @(posedge clk);
        battery_cleared <= 1'b0;
        flash_erase <= 1'b0;
        upd_req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        // ---------------------------------------------------------------
        // reset values, unmapped, narrow-band path
        // ---------------------------------------------------------------
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        rd(`IMCL_ADDR_CTRL, 0, 32'h3);
        rd(`IMCL_ADDR_THR, 32'h0A0A, 32'hFFFF);
        rd(`IMCL_ADDR_STATUS, 0, 32'h3);
        rd(4'hF, `IMCL_UNMAPPED_DATA, 32'hFFFFFFFF);
        repeat (3) begin
            s = lfsr(s);
            @(posedge clk);
            cw_db <= s[7:0];
            repeat (3) @(posedge clk);
            `CHK(narrowband_jam_level, s[7:0])
            `CHK(cw_alarm, s[7:0] > 8'h0A)
            rd(`IMCL_ADDR_NOISE, {24'h0, s[7:0]}, 32'hFF);
            rd(`IMCL_ADDR_STATUS, {29'h0, s[7:0] > 8'h0A, 2'h0}, 32'h7);
        end
        `CHK(spoof_detect, 1'b0)
        spoof_suspect <= 0;
        repeat (2) @(posedge clk);
        spoof_suspect <= 1;
        repeat (3) @(posedge clk);
        `CHK(spoof_detect, 1'b1)
        // ---------------------------------------------------------------
        // broadband monitor states
        // ---------------------------------------------------------------
        noise_db <= 8'h28;
        bus(1'b1, `IMCL_ADDR_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        rd(`IMCL_ADDR_STATUS, 0, 32'h3);
        foreach (tbl[i]) begin
            bus(1'b1, `IMCL_ADDR_CTRL, tbl[i][19:16]);
            noise_db <= tbl[i][15:8];
            fix_valid <= tbl[i][4];
            antenna_ok <= !tbl[i][5];
            repeat (4) @(posedge clk);
            `CHK(bb_state, tbl[i][1:0])
            rd(`IMCL_ADDR_STATUS, tbl[i][3:0], 32'h3);
        end
        // ---------------------------------------------------------------
        // settings lock per layer
        // ---------------------------------------------------------------
        bus(1'b1, `IMCL_ADDR_LOCK, 32'h1);
        bus(1'b1, `IMCL_ADDR_THR, 32'h1414);
        rd(`IMCL_ADDR_THR, 32'h0A0A, 32'hFFFF);
        rd(`IMCL_ADDR_LOCK, 32'h18, 32'hF8);
        do_reset();
        bus(1'b1, `IMCL_ADDR_THR, 32'h1414);
        rd(`IMCL_ADDR_THR, 32'h1414, 32'hFFFF);
        bus(1'b1, `IMCL_ADDR_LOCK, 32'h2);
        rd(`IMCL_ADDR_LOCK, 32'h8, 32'h8);
        pulse(0);
        rd(`IMCL_ADDR_LOCK, 0, 32'h8);
        bus(1'b1, `IMCL_ADDR_LOCK, 32'h4);
        repeat (3) @(posedge clk);
        `CHK(flash_lock_out, 1'b1)
        do_reset();
        rd(`IMCL_ADDR_LOCK, 32'h8, 32'h8);
        pulse(1);
        rd(`IMCL_ADDR_LOCK, 0, 32'h8);
        // ---------------------------------------------------------------
        // boot and update signature gating
        // ---------------------------------------------------------------
        `CHK(fw_run, 1'b1)
        rd(`IMCL_ADDR_BOOT, 32'h1, 32'h3);
        pulse(2);
        `CHK(rej_n, 8'h01)
        upd_good <= 1;
        pulse(2);
        `CHK(acc_n, 8'h01)
        boot_good <= 0;
        do_reset();
        `CHK(fw_run, 1'b0)
        rd(`IMCL_ADDR_BOOT, 32'h2, 32'h3);
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
